// ==== hdl/ccd_regs.sv ====
`timescale 1ns/10ps
// capability, implementation and debug control/status registers
module ccd_regs (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic clk_en,
    // coprocessor register access
    input wire logic [4:0] reg_num,
    input wire logic [2:0] reg_sel,
    input wire logic reg_wr,
    input wire logic [31:0] reg_wdata,
    output logic [31:0] reg_rdata,
    // debug events from the pipeline
    input wire logic dbg_exc,
    input wire logic exc_in_debug,
    input wire logic debug_return,
    input wire logic evt_delay_slot,
    input wire logic [8:0] evt_cause,
    input wire logic [4:0] evt_exc_code,
    input wire logic evt_low_power,
    input wire logic evt_bus_clk_run,
    // wait handling
    input wire logic wait_enter,
    input wire logic int_pending,
    input wire logic global_int_enable,
    output logic in_wait,
    output logic wake_resume,
    output logic wake_vector,
    // control outputs
    output logic user_fp_mode_access,
    output logic debug_mode_flag,
    output logic segment_routing_bit,
    output logic count_in_debug,
    output logic no_debug_segment
);
    logic ufr_q;
    logic dm_q;
    logic route_q;
    logic cnt_q;
    logic dbd_q;
    logic doze_q;
    logic halt_q;
    logic [8:0] cause_q;
    logic [4:0] exc_q;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;

    // address decode
    wire sel_cap = (reg_num == ccd_pkg::CAP_REG_NUM) && (reg_sel == ccd_pkg::CAP_SEL);
    wire sel_impl = (reg_num == ccd_pkg::IMPL_REG_NUM) && (reg_sel == ccd_pkg::IMPL_SEL);
    wire sel_dbg = (reg_num == ccd_pkg::DBG_REG_NUM) && (reg_sel == ccd_pkg::DBG_SEL);
    wire wr_cap = reg_wr & sel_cap;
    // writes outside debug mode are dropped, behaviour left undefined there [R10]
    wire wr_dbg = reg_wr & sel_dbg & dm_q;
    wire dbg_event = dbg_exc | (exc_in_debug & dm_q); // [R08]
    wire in_dbg_exc = exc_in_debug & dm_q;

    // assembled images; constant fields have no storage [R21]
    wire [31:0] cap_img = {1'b0, 28'h0, ufr_q, 1'b0, ccd_pkg::CAP_NESTED_VAL}; // [R01] [R03]
    wire [31:0] impl_img = {ccd_pkg::IMPL_WII_VAL, 12'h0, ccd_pkg::IMPL_HCI_VAL,
        18'h0}; // [R04] [R06] [R07]
    wire [31:0] dbg_img = {dbd_q, dm_q, ccd_pkg::DBG_NOSEG_VAL, route_q, doze_q, halt_q,
        cnt_q, 5'h0, cause_q[8:7], ccd_pkg::DBG_VER_VAL, exc_q, 3'h0,
        cause_q[6:0]}; // [R14] [R15] [R16]
    // outside debug mode only mode flag and version are guaranteed [R09]
    wire [31:0] dbg_view = dm_q ? dbg_img :
        {1'b0, dm_q, 12'h0, ccd_pkg::DBG_VER_VAL, 15'h0};

    assign rdata_d = sel_cap ? cap_img : sel_impl ? impl_img : sel_dbg ? dbg_view : 32'h0;
    assign reg_rdata = rdata_q;
    assign user_fp_mode_access = ufr_q; // [R02]
    assign debug_mode_flag = dm_q;
    assign segment_routing_bit = route_q; // [R17]
    assign count_in_debug = cnt_q; // [R20]
    assign no_debug_segment = ccd_pkg::DBG_NOSEG_VAL; // [R16]

    // writable controls
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            ufr_q <= ccd_pkg::CAP_UFR_RESET;
            route_q <= ccd_pkg::DBG_ROUTE_RESET;
            cnt_q <= ccd_pkg::DBG_CNT_RESET;
        end else if (clk_en) begin
            if (wr_cap) begin
                ufr_q <= reg_wdata[ccd_pkg::CAP_UFR_BIT]; // [R02]
            end
            if (wr_dbg) begin
                route_q <= reg_wdata[ccd_pkg::DBG_ROUTE_BIT]; // [R17]
                cnt_q <= reg_wdata[ccd_pkg::DBG_CNT_BIT]; // [R20]
            end
        end
    end

    // debug mode tracking
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            dm_q <= 1'b0;
        end else if (clk_en) begin
            if (dbg_exc) begin
                dm_q <= 1'b1; // [R15]
            end else if (debug_return) begin
                dm_q <= 1'b0;
            end
        end
    end

    // captured information fields; slot and cause refreshed on every debug event
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            dbd_q <= 1'b0;
            cause_q <= 9'h0;
            exc_q <= 5'h0;
            doze_q <= 1'b0;
            halt_q <= 1'b0;
        end else if (clk_en && dbg_event) begin
            dbd_q <= evt_delay_slot; // [R14]
            cause_q <= evt_cause; // [R11]
            if (in_dbg_exc) begin
                exc_q <= evt_exc_code; // [R12]
            end else begin
                doze_q <= evt_low_power; // [R13] [R18]
                halt_q <= evt_bus_clk_run; // [R19]
            end
        end
    end

    // registered read data
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            rdata_q <= 32'h0;
        end else if (clk_en) begin
            rdata_q <= rdata_d;
        end
    end

    ccd_wake_ctl u_wake (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .clk_en(clk_en),
        .wait_enter(wait_enter),
        .int_pending(int_pending),
        .global_int_enable(global_int_enable),
        .in_wait(in_wait),
        .wake_resume(wake_resume),
        .wake_vector(wake_vector)
    );

    sequence s_dbg_entry;
        clk_en && dbg_exc && !dm_q;
    endsequence
    sequence s_fields_caught;
        dm_q && doze_q == $past(evt_low_power) && halt_q == $past(evt_bus_clk_run);
    endsequence

    a_cap_fixed_bits: assert property (@(posedge sys_clk) disable iff (!nrst)
        (clk_en && $past(clk_en) && $past(sel_cap)) |-> (!reg_rdata[31] && reg_rdata[0]))
        else $error("capability fixed bits wrong"); // [R01]
    a_impl_fixed: assert property (@(posedge sys_clk) disable iff (!nrst)
        ($past(clk_en) && $past(sel_impl)) |-> reg_rdata == 32'h80000000)
        else $error("implementation register image wrong"); // [R06]
    a_ufr_write: assert property (@(posedge sys_clk) disable iff (!nrst)
        (clk_en && wr_cap) |=> user_fp_mode_access == $past(reg_wdata[2]))
        else $error("fp access bit not written"); // [R02]
    a_entry_capture: assert property (@(posedge sys_clk) disable iff (!nrst)
        s_dbg_entry |=> s_fields_caught)
        else $error("power and clock flags not captured"); // [R13]
    a_cause_update: assert property (@(posedge sys_clk) disable iff (!nrst)
        (clk_en && dbg_event) |=> cause_q == $past(evt_cause) && dbd_q == $past(evt_delay_slot))
        else $error("cause flags not refreshed"); // [R11]
    a_exc_code: assert property (@(posedge sys_clk) disable iff (!nrst)
        (clk_en && in_dbg_exc) |=> exc_q == $past(evt_exc_code))
        else $error("debug cause code not written"); // [R12]
    a_no_write_normal: assert property (@(posedge sys_clk) disable iff (!nrst)
        (reg_wr && sel_dbg && !dm_q) |=> $stable(route_q) && $stable(cnt_q))
        else $error("debug register written outside debug"); // [R10]
    a_nondebug_view: assert property (@(posedge sys_clk) disable iff (!nrst)
        ($past(clk_en) && $past(sel_dbg) && !$past(dm_q)) |-> reg_rdata[17:15] == 3'h5
        && !reg_rdata[30])
        else $error("mode or version wrong outside debug"); // [R09]
endmodule : ccd_regs

// ==== hdl/ccd_wake_ctl.sv ====
`timescale 1ns/10ps
// wait wakeup control: interrupt ends wait regardless of the global enable
module ccd_wake_ctl (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic clk_en,
    input wire logic wait_enter,
    input wire logic int_pending,
    input wire logic global_int_enable,
    output logic in_wait,
    output logic wake_resume,
    output logic wake_vector
);
    logic wait_q;
    logic wait_d;
    wire wake_now = wait_q & int_pending; // enable ignored here [R04]

    // vector only when enable allows, otherwise resume after wait [R05]
    assign wake_resume = wake_now & ~global_int_enable;
    assign wake_vector = wake_now & global_int_enable;
    assign in_wait = wait_q;
    assign wait_d = wake_now ? 1'b0 : (wait_q | wait_enter);

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            wait_q <= 1'b0;
        end else if (clk_en) begin
            wait_q <= wait_d;
        end
    end

    a_wake_no_vector: assert property (@(posedge sys_clk) disable iff (!nrst)
        (wait_q && int_pending && !global_int_enable) |-> !wake_vector && wake_resume)
        else $error("wake with enable low must not vector"); // [R05]
    a_wake_ends_wait: assert property (@(posedge sys_clk) disable iff (!nrst)
        (clk_en && wait_q && int_pending) |=> !wait_q)
        else $error("pending interrupt did not release wait"); // [R04]
endmodule : ccd_wake_ctl

// ==== pkg/ccd_pkg.sv ====
// Operation
// R01: capability top bit always reads zero
// R02: user fp mode access bit, r/w, reset zero
// R03: nested fault present bit reads one
// R04: wait ignores enable bit reads one
// R05: wake with enable low resumes, no vector
// R06: unused implementation bits read zero
// R07: hardware cache init bit reads zero
// R08: info fields refresh on debug events
// R09: outside debug only mode and version valid
// R10: software writes debug reg only in debug
// R11: cause flags update on both event kinds
// R12: cause code written on in-debug exceptions
// R13: power and clock flags captured on debug exception
// R14: delay slot flag reflects latest event
// R15: debug mode flag, reset zero
// R16: no debug segment flag, reset zero
// R17: segment routing bit r/w, reset zero
// R18: low power flag captured at exception
// R19: bus clock flag captured at exception
// R20: count in debug r/w, reset one
// R21: read-only field writes have no effect
package ccd_pkg;
    // register and select numbers
    localparam logic [4:0] CAP_REG_NUM = 5'h10;
    localparam logic [2:0] CAP_SEL = 3'h5;
    localparam logic [4:0] IMPL_REG_NUM = 5'h10;
    localparam logic [2:0] IMPL_SEL = 3'h7;
    localparam logic [4:0] DBG_REG_NUM = 5'h17;
    localparam logic [2:0] DBG_SEL = 3'h0;
    // capability register fields
    localparam int CAP_MORE_BIT = 31;
    localparam int CAP_UFR_BIT = 2;
    localparam int CAP_NESTED_BIT = 0;
    localparam logic CAP_UFR_RESET = 1'h0;
    localparam logic CAP_NESTED_VAL = 1'h1;
    // implementation register fields
    localparam int IMPL_WII_BIT = 31;
    localparam int IMPL_HCI_BIT = 18;
    localparam logic IMPL_WII_VAL = 1'h1;
    localparam logic IMPL_HCI_VAL = 1'h0;
    // debug register fields
    localparam int DBG_DBD_BIT = 31;
    localparam int DBG_DM_BIT = 30;
    localparam int DBG_NOSEG_BIT = 29;
    localparam int DBG_ROUTE_BIT = 28;
    localparam int DBG_DOZE_BIT = 27;
    localparam int DBG_HALT_BIT = 26;
    localparam int DBG_CNT_BIT = 25;
    localparam int DBG_VER_LO = 15;
    localparam int DBG_EXC_LO = 10;
    localparam int DBG_CAUSE_W = 9;
    localparam logic DBG_NOSEG_VAL = 1'h0;
    localparam logic DBG_ROUTE_RESET = 1'h0;
    localparam logic DBG_CNT_RESET = 1'h1;
    localparam logic [2:0] DBG_VER_VAL = 3'h5;
    // cause vector order: imprecise store, imprecise load, imprecise ib,
    // debug_interrupt_cause, dib, store, load, bp, ss -> bits 19,18,6,5,4,3,2,1,0
    typedef enum logic [1:0] {
        CCD_RUN = 2'h0,
        CCD_DEBUG = 2'h1
    } ccd_mode_t;
endpackage : ccd_pkg

// ==== sim/ccd_regs_tb.sv ====
`timescale 1ns/10ps
// self-checking bench: register reads and writes, debug events, wait wakeup
module ccd_regs_tb;
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    logic clk_en = 1'b1;
    logic [4:0] reg_num = 5'h00;
    logic [2:0] reg_sel = 3'h0;
    logic reg_wr = 1'b0;
    logic [31:0] reg_wdata = 32'h00000000;
    logic [31:0] reg_rdata;
    logic dbg_exc = 1'b0;
    logic exc_in_debug = 1'b0;
    logic debug_return = 1'b0;
    logic evt_delay_slot = 1'b0;
    logic [8:0] evt_cause = 9'h000;
    logic [4:0] evt_exc_code = 5'h00;
    logic evt_low_power = 1'b0;
    logic evt_bus_clk_run = 1'b0;
    logic wait_enter = 1'b0;
    logic int_pending = 1'b0;
    logic global_int_enable = 1'b0;
    logic in_wait, wake_resume, wake_vector;
    logic user_fp_mode_access, debug_mode_flag, segment_routing_bit;
    logic count_in_debug, no_debug_segment;
    logic [31:0] rd;
    int failures = 0;
    int cmp_count = 0;

    // 100 MHz
    always #5 sys_clk = ~sys_clk;

    ccd_regs i_ccd_regs (.sys_clk(sys_clk), .nrst(nrst), .clk_en(clk_en),
        .reg_num(reg_num), .reg_sel(reg_sel), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .dbg_exc(dbg_exc), .exc_in_debug(exc_in_debug),
        .debug_return(debug_return), .evt_delay_slot(evt_delay_slot),
        .evt_cause(evt_cause), .evt_exc_code(evt_exc_code), .evt_low_power(evt_low_power),
        .evt_bus_clk_run(evt_bus_clk_run), .wait_enter(wait_enter),
        .int_pending(int_pending), .global_int_enable(global_int_enable),
        .in_wait(in_wait), .wake_resume(wake_resume), .wake_vector(wake_vector),
        .user_fp_mode_access(user_fp_mode_access), .debug_mode_flag(debug_mode_flag),
        .segment_routing_bit(segment_routing_bit), .count_in_debug(count_in_debug),
        .no_debug_segment(no_debug_segment));

    // case equality so an unknown never matches
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // read data is registered: sample one edge after the address
    task automatic rd_reg(input logic [4:0] n, input logic [2:0] s);
        @(posedge sys_clk);
        reg_num <= n;
        reg_sel <= s;
        reg_wr <= 1'b0;
        @(posedge sys_clk);
        #1;
        rd = reg_rdata;
    endtask : rd_reg

    task automatic wr_reg(input logic [4:0] n, input logic [2:0] s, input logic [31:0] d);
        @(posedge sys_clk);
        reg_num <= n;
        reg_sel <= s;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        #1;
    endtask : wr_reg

    // one-cycle event pulse with its info sampled alongside
    task automatic evt(input logic in_dbg, input logic ds, input logic [8:0] cause,
                       input logic [4:0] code, input logic lp, input logic bc);
        @(posedge sys_clk);
        dbg_exc <= ~in_dbg;
        exc_in_debug <= in_dbg;
        evt_delay_slot <= ds;
        evt_cause <= cause;
        evt_exc_code <= code;
        evt_low_power <= lp;
        evt_bus_clk_run <= bc;
        @(posedge sys_clk);
        dbg_exc <= 1'b0;
        exc_in_debug <= 1'b0;
        #1;
    endtask : evt

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : summarize

    initial begin
        repeat (4) @(posedge sys_clk);
        nrst <= 1'b1;
        #1;
        check("count_in_debug", {31'h0, count_in_debug}, 32'h1);
        check("routing", {31'h0, segment_routing_bit}, 32'h0);
        check("no_seg", {31'h0, no_debug_segment}, 32'h0);
        rd_reg(ccd_pkg::CAP_REG_NUM, ccd_pkg::CAP_SEL);
        check("cap reset", rd, 32'h00000001);
        rd_reg(ccd_pkg::IMPL_REG_NUM, ccd_pkg::IMPL_SEL);
        check("impl reset", rd, 32'h80000000);
        rd_reg(ccd_pkg::DBG_REG_NUM, ccd_pkg::DBG_SEL);
        check("dbg reset", rd & 32'h40038000, 32'h00028000);
        rd_reg(5'h01, 3'h2);
        check("unmapped", rd, 32'h00000000);
        $display("test reset done");
        // writes to constant bits must not stick
        wr_reg(ccd_pkg::CAP_REG_NUM, ccd_pkg::CAP_SEL, 32'hFFFFFFFF);
        rd_reg(ccd_pkg::CAP_REG_NUM, ccd_pkg::CAP_SEL);
        check("cap ones", rd, 32'h00000005);
        check("ufr out", {31'h0, user_fp_mode_access}, 32'h1);
        wr_reg(ccd_pkg::IMPL_REG_NUM, ccd_pkg::IMPL_SEL, 32'hFFFFFFFF);
        rd_reg(ccd_pkg::IMPL_REG_NUM, ccd_pkg::IMPL_SEL);
        check("impl ones", rd, 32'h80000000);
        wr_reg(ccd_pkg::DBG_REG_NUM, ccd_pkg::DBG_SEL, 32'h10000000);
        check("route ignored", {31'h0, segment_routing_bit}, 32'h0);
        check("count kept", {31'h0, count_in_debug}, 32'h1);
        $display("test writes done");
        // debug exception: doze, halt, cause and slot captured
        evt(1'b0, 1'b1, 9'h1FF, 5'h1F, 1'b1, 1'b0);
        check("mode in", {31'h0, debug_mode_flag}, 32'h1);
        rd_reg(ccd_pkg::DBG_REG_NUM, ccd_pkg::DBG_SEL);
        check("dbg exc", rd & 32'hFE0F807F, 32'hCA0E807F);
        wr_reg(ccd_pkg::DBG_REG_NUM, ccd_pkg::DBG_SEL, 32'hFDFFFFFF);
        rd_reg(ccd_pkg::DBG_REG_NUM, ccd_pkg::DBG_SEL);
        check("dbg write", rd & 32'hFE0F807F, 32'hD80E807F);
        check("route out", {31'h0, segment_routing_bit}, 32'h1);
        // exception in debug: code written, flags refreshed, halt/doze free
        evt(1'b1, 1'b0, 9'h000, 5'h0A, 1'b0, 1'b1);
        rd_reg(ccd_pkg::DBG_REG_NUM, ccd_pkg::DBG_SEL);
        check("dbg in-exc", rd & 32'hF20FFC7F, 32'h5002A800);
        @(posedge sys_clk);
        debug_return <= 1'b1;
        @(posedge sys_clk);
        debug_return <= 1'b0;
        #1;
        check("mode out", {31'h0, debug_mode_flag}, 32'h0);
        rd_reg(ccd_pkg::DBG_REG_NUM, ccd_pkg::DBG_SEL);
        check("dbg normal", rd & 32'h40038000, 32'h00028000);
        $display("test debug done");
        // frozen clock enable drops the write
        clk_en <= 1'b0;
        wr_reg(ccd_pkg::CAP_REG_NUM, ccd_pkg::CAP_SEL, 32'h00000000);
        clk_en <= 1'b1;
        rd_reg(ccd_pkg::CAP_REG_NUM, ccd_pkg::CAP_SEL);
        check("cap frozen", rd, 32'h00000005);
        wr_reg(ccd_pkg::CAP_REG_NUM, ccd_pkg::CAP_SEL, 32'h00000000);
        rd_reg(ccd_pkg::CAP_REG_NUM, ccd_pkg::CAP_SEL);
        check("cap clear", rd, 32'h00000001);
        $display("test enable done");
        // wait released by interrupt: enable low resumes without vector, enable high vectors
        @(posedge sys_clk);
        wait_enter <= 1'b1;
        @(posedge sys_clk);
        wait_enter <= 1'b0;
        #1;
        check("in_wait", {31'h0, in_wait}, 32'h1);
        check("no early wake", {31'h0, wake_resume}, 32'h0);
        @(posedge sys_clk);
        int_pending <= 1'b1;
        #1;
        check("resume", {31'h0, wake_resume}, 32'h1);
        check("no vector", {31'h0, wake_vector}, 32'h0);
        @(posedge sys_clk);
        #1;
        check("wait released", {31'h0, in_wait}, 32'h0);
        @(posedge sys_clk);
        int_pending <= 1'b0;
        global_int_enable <= 1'b1;
        wait_enter <= 1'b1;
        @(posedge sys_clk);
        wait_enter <= 1'b0;
        int_pending <= 1'b1;
        #1;
        check("vector", {31'h0, wake_vector}, 32'h1);
        $display("test wait done");
        summarize();
    end
endmodule : ccd_regs_tb
